// ### verilog/pbs_port.sv
// pipelined burst sram port: input stage, burst counter, array, output stage
//
// Summary of operation
// - every synchronous input is captured on the rising clock edge.
// - address and chip enables load only when a strobe is active.
// - a 2-bit counter makes later burst addresses, stepping on advance.
// - interleaved order when order select high, linear when low.
// - address, data and write controls registered together, then written.
// - only selected byte lanes are written: any combination of the four lanes.
// - all-bytes write low writes every lane regardless of lane inputs.
// - output enable and sleep act without waiting for a clock edge.
// - inputs and read data both registered, read data two stages later.
// - four-beat burst gives first word after three cycles, then one apart.
// - separate processor and controller strobes, either starts an access.
`timescale 1ns/100ps
`include "pbs_regs.svh"
module pbs_port (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic [`PBS_ADDR_W-1:0] addr_in,
  input wire pbs_pkg::pbs_word_t word_in,
  input wire logic chip_select_primary_n_in,
  input wire logic chip_select_depth_hi_in,
  input wire logic chip_select_depth_lo_n_in,
  input wire logic processor_addr_strobe_n_in,
  input wire logic controller_addr_strobe_n_in,
  input wire logic burst_advance_n_in,
  input wire logic [`PBS_LANES-1:0] byte_write_lane_n_in,
  input wire logic byte_write_master_n_in,
  input wire logic all_bytes_write_n_in,
  input wire logic output_enable_n_in,
  input wire logic sleep_request_in,
  input wire logic burst_order_sel_in,
  output pbs_pkg::pbs_word_t word_out,
  output logic word_oe_n_out
);
  import pbs_pkg::*;

  pbs_state_t st;
  pbs_state_t next_st;
  pbs_in_t q;
  pbs_word_t mem_rdata;
  logic wr_any;
  logic sel;
  logic p_start;
  logic start;
  logic acc_en;
  logic acc_wr;
  logic [`PBS_LANES-1:0] lanes;
  logic [`PBS_CNT_W-1:0] lsb;
  logic [`PBS_ADDR_W-1:0] acc_addr;

  ////////////////////////////////////////////////////////////////
  // decode of the registered inputs
  always_comb begin
    q = st.inp;
    wr_any = !q.all_bytes_write_n ||
             (!q.byte_write_master_n && (q.byte_write_lane_n != '1));
    if (!q.all_bytes_write_n) begin
      lanes = '1;
    end else if (!q.byte_write_master_n) begin
      lanes = ~q.byte_write_lane_n;
    end else begin
      lanes = '0;
    end
    sel = !q.chip_select_primary_n && q.chip_select_depth_hi &&
          !q.chip_select_depth_lo_n;
    // processor strobe is ignored while the primary select is high
    p_start = !q.processor_addr_strobe_n && !q.chip_select_primary_n;
    start = p_start || !q.controller_addr_strobe_n;
  end

  ////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_st = st;
    acc_en = 1'b0;
    acc_wr = 1'b0;
    // input stage
    next_st.inp.addr = addr_in;
    next_st.inp.word = word_in;
    next_st.inp.chip_select_primary_n = chip_select_primary_n_in;
    next_st.inp.chip_select_depth_hi = chip_select_depth_hi_in;
    next_st.inp.chip_select_depth_lo_n = chip_select_depth_lo_n_in;
    next_st.inp.processor_addr_strobe_n = processor_addr_strobe_n_in;
    next_st.inp.controller_addr_strobe_n = controller_addr_strobe_n_in;
    next_st.inp.burst_advance_n = burst_advance_n_in;
    next_st.inp.byte_write_lane_n = byte_write_lane_n_in;
    next_st.inp.byte_write_master_n = byte_write_master_n_in;
    next_st.inp.all_bytes_write_n = all_bytes_write_n_in;
    next_st.inp.interleaved = burst_order_sel_in;

    if (start) begin
      next_st.base = q.addr;
      next_st.cnt = `PBS_CNT_ZERO;
      next_st.phase = sel ? PBS_BURST : PBS_IDLE;
      acc_en = sel;
      // a processor-strobe start is always a read; write follows later
      acc_wr = sel && !p_start && wr_any;
    end else begin
      unique case (st.phase)
        PBS_IDLE: begin
          next_st.phase = PBS_IDLE;
        end
        PBS_BURST: begin
          if (!q.burst_advance_n) begin
            next_st.cnt = st.cnt + `PBS_CNT_STEP;
          end
          acc_en = 1'b1;
          acc_wr = wr_any;
        end
      endcase
    end

    // sleep blocks array activity at once
    if (sleep_request_in) begin
      acc_en = 1'b0;
      acc_wr = 1'b0;
      next_st.phase = PBS_IDLE;
    end

    next_st.rd_pend = acc_en && !acc_wr;
    next_st.rd_vld = st.rd_pend;
    if (st.rd_pend) begin
      next_st.dout = mem_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////
  // burst address
  always_comb begin
    if (start) begin
      lsb = q.addr[`PBS_LSB_HI:0];
      acc_addr = q.addr;
    end else begin
      if (q.interleaved) begin
        lsb = st.base[`PBS_LSB_HI:0] ^ next_st.cnt;
      end else begin
        lsb = st.base[`PBS_LSB_HI:0] + next_st.cnt;
      end
      acc_addr = {st.base[`PBS_ADDR_W-1:`PBS_BASE_LO], lsb};
    end
  end

  ////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////
  // array
  pbs_mem u_mem (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .wr_en_in(acc_en && acc_wr),
    .rd_en_in(acc_en && !acc_wr),
    .addr_in(acc_addr),
    .lane_en_in(lanes),
    .wdata_in(q.word),
    .rdata_out(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////
  // outputs; enable path is asynchronous
  assign word_out = st.dout;
  assign word_oe_n_out = !(st.rd_vld && !output_enable_n_in &&
                           !sleep_request_in);
endmodule : pbs_port

// ### verilog/pbs_regs.svh
// widths and field constants for the pipelined burst sram port
`ifndef PBS_REGS_SVH
`define PBS_REGS_SVH
`define PBS_ADDR_W 21
`define PBS_LANES 4
`define PBS_BYTE_W 8
`define PBS_DATA_W 32
`define PBS_WORD_W 36
`define PBS_CNT_W 2
`define PBS_CNT_STEP 2'h1
`define PBS_CNT_ZERO 2'h0
`define PBS_LSB_HI 1
`define PBS_BASE_LO 2
`endif

// ### verilog/pbs_pkg.sv
// types shared by the burst sram port and its array
`include "pbs_regs.svh"
package pbs_pkg;
  typedef struct packed {
    logic [`PBS_DATA_W-1:0] data;
    logic [`PBS_LANES-1:0] lane_parity_bit;
  } pbs_word_t;

  typedef struct packed {
    logic [`PBS_ADDR_W-1:0] addr;
    pbs_word_t word;
    logic chip_select_primary_n;
    logic chip_select_depth_hi;
    logic chip_select_depth_lo_n;
    logic processor_addr_strobe_n;
    logic controller_addr_strobe_n;
    logic burst_advance_n;
    logic [`PBS_LANES-1:0] byte_write_lane_n;
    logic byte_write_master_n;
    logic all_bytes_write_n;
    logic interleaved;
  } pbs_in_t;

  typedef enum logic {PBS_IDLE, PBS_BURST} pbs_phase_t;

  typedef struct packed {
    pbs_in_t inp;
    pbs_phase_t phase;
    logic [`PBS_ADDR_W-1:0] base;
    logic [`PBS_CNT_W-1:0] cnt;
    logic rd_pend;
    logic rd_vld;
    pbs_word_t dout;
  } pbs_state_t;

  typedef struct packed {
    pbs_word_t rdata;
  } pbs_mem_state_t;
endpackage : pbs_pkg

// ### verilog/pbs_mem.sv
// storage array with per-lane write and registered read data
`timescale 1ns/100ps
`include "pbs_regs.svh"
module pbs_mem (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [`PBS_ADDR_W-1:0] addr_in,
  input wire logic [`PBS_LANES-1:0] lane_en_in,
  input wire pbs_pkg::pbs_word_t wdata_in,
  output pbs_pkg::pbs_word_t rdata_out
);
  import pbs_pkg::*;

  pbs_mem_state_t st;
  pbs_mem_state_t next_st;
  logic [`PBS_LANES-1:0][`PBS_BYTE_W:0] lane_rd;

  ////////////////////////////////////////////////////////////////
  // lane writes: data byte plus its parity bit
  // one array per lane, so each array has a single writing process
  genvar i;
  generate
    for (i = 0; i < `PBS_LANES; i++) begin : g_lane
      logic [`PBS_BYTE_W:0] lane_mem [0:(2**`PBS_ADDR_W)-1];
      always_ff @(posedge sys_clk_in) begin
        if (wr_en_in && lane_en_in[i]) begin
          lane_mem[addr_in] <= {wdata_in.lane_parity_bit[i],
                                wdata_in.data[i*`PBS_BYTE_W +: `PBS_BYTE_W]};
        end
      end
      assign lane_rd[i] = lane_mem[addr_in];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // read register
  always_comb begin
    next_st = st;
    if (rd_en_in) begin
      for (int j = 0; j < `PBS_LANES; j++) begin
        next_st.rdata.data[j*`PBS_BYTE_W +: `PBS_BYTE_W] = lane_rd[j][`PBS_BYTE_W-1:0];
        next_st.rdata.lane_parity_bit[j] = lane_rd[j][`PBS_BYTE_W];
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata_out = st.rdata;
endmodule : pbs_mem

// ### bench/pbs_monitor.sv
// pin checks on the burst sram port
`timescale 1ns/100ps
`include "pbs_regs.svh"
module pbs_monitor (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  input wire logic chip_select_primary_n_in,
  input wire logic chip_select_depth_hi_in,
  input wire logic chip_select_depth_lo_n_in,
  input wire logic processor_addr_strobe_n_in,
  input wire logic controller_addr_strobe_n_in,
  input wire logic burst_advance_n_in,
  input wire logic [`PBS_LANES-1:0] byte_write_lane_n_in,
  input wire logic byte_write_master_n_in,
  input wire logic all_bytes_write_n_in,
  input wire logic output_enable_n_in,
  input wire logic sleep_request_in,
  input wire pbs_pkg::pbs_word_t word_out,
  input wire logic word_oe_n_out
);
  import pbs_pkg::*;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!arst_n_in);
  logic sel, wr, qt, ok, rs, bt;
  assign sel = !chip_select_primary_n_in && chip_select_depth_hi_in && !chip_select_depth_lo_n_in;
  assign wr = !all_bytes_write_n_in || !byte_write_master_n_in && !(&byte_write_lane_n_in);
  assign qt = processor_addr_strobe_n_in && controller_addr_strobe_n_in;
  assign ok = !output_enable_n_in && !sleep_request_in;
  assign rs = sel && !sleep_request_in && (controller_addr_strobe_n_in ?
    !processor_addr_strobe_n_in : !wr);
  assign bt = qt && !burst_advance_n_in && !wr && !sleep_request_in;
  a_oe_async: assert property (output_enable_n_in |-> word_oe_n_out)
    else $error("pins driven with oe high");
  a_sleep_off: assert property (sleep_request_in |-> word_oe_n_out)
    else $error("pins driven in sleep");
  a_read_lat: assert property (rs ##1 !sleep_request_in [*2] ##1 ok |-> !word_oe_n_out)
    else $error("read data late");
  a_last_beat: assert property (rs ##1 (bt && ok) [*3] ##1 ok [*3] |-> !word_oe_n_out)
    else $error("fourth beat missing");
  a_deselect: assert property (!controller_addr_strobe_n_in && !chip_select_depth_hi_in
    |-> ##3 word_oe_n_out) else $error("deselect drove pins");
  a_write_quiet: assert property (!controller_addr_strobe_n_in && !all_bytes_write_n_in
    |-> ##3 word_oe_n_out) else $error("write drove pins");
  a_sleep_abort: assert property (rs ##1 (sleep_request_in && qt) |-> ##2 word_oe_n_out)
    else $error("access in sleep");
  a_hold_data: assert property ($changed(word_out) |-> !word_oe_n_out || !ok)
    else $error("data moved without read");
  c_burst: cover property (rs ##1 bt [*3]);
  c_write: cover property (sel && !controller_addr_strobe_n_in && !all_bytes_write_n_in);
  c_abort: cover property (rs ##1 sleep_request_in);
endmodule : pbs_monitor

// ### bench/pbs_host.sv
// host bus model driving the port inputs
`timescale 1ns/100ps
module pbs_host (
  input wire logic sys_clk_in,
  output pbs_pkg::pbs_in_t bus_out
);
  import pbs_pkg::*;
  pbs_in_t v;
  initial bus_out = '1;
  task automatic beat(input pbs_in_t c);
    @(negedge sys_clk_in);
    bus_out <= c;
  endtask : beat
  // released bus: no strobe, no write, data lines toggled
  task automatic idle();
    @(negedge sys_clk_in);
    v = '1;
    v.word = ~bus_out.word;
    v.interleaved = bus_out.interleaved;
    bus_out <= v;
  endtask : idle
endmodule : pbs_host

// ### bench/pbs_tb.sv
// self-checking bench for the burst sram port
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %0t %h %h", $time, g, e); end end
module testbench;
  import pbs_pkg::*;
  logic sys_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic oe_n = 1'b0;
  logic sleep = 1'b0;
  logic ord = 1'b1;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  pbs_in_t b, s;
  pbs_word_t q, w;
  logic qe;
  logic [20:0] a;
  logic [3:0] ln_tab [4] = '{4'he, 4'hc, 4'h0, 4'h3};
  pbs_word_t mem [logic [20:0]];
  always #4 sys_clk_in = ~sys_clk_in;
  pbs_host u_host (.sys_clk_in(sys_clk_in), .bus_out(b));
  pbs_port u_dut (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .addr_in(b.addr),
    .word_in(b.word), .chip_select_primary_n_in(b.chip_select_primary_n),
    .chip_select_depth_hi_in(b.chip_select_depth_hi),
    .chip_select_depth_lo_n_in(b.chip_select_depth_lo_n),
    .processor_addr_strobe_n_in(b.processor_addr_strobe_n),
    .controller_addr_strobe_n_in(b.controller_addr_strobe_n),
    .burst_advance_n_in(b.burst_advance_n), .byte_write_lane_n_in(b.byte_write_lane_n),
    .byte_write_master_n_in(b.byte_write_master_n), .all_bytes_write_n_in(b.all_bytes_write_n),
    .output_enable_n_in(oe_n), .sleep_request_in(sleep), .burst_order_sel_in(b.interleaved),
    .word_out(q), .word_oe_n_out(qe));
  function automatic pbs_in_t cmd(logic [20:0] ad, pbs_word_t d, logic c, logic [3:0] ln,
    logic g);
    return '{ad, d, 1'b0, 1'b1, 1'b0, c, !c, 1'b1, ln, &ln, g, ord};
  endfunction : cmd
  function automatic pbs_word_t merge(pbs_word_t o, pbs_word_t n, logic [3:0] ln);
    for (int i = 0; i < 4; i++) begin
      if (!ln[i]) begin
        o.data[8*i+:8] = n.data[8*i+:8];
        o.lane_parity_bit[i] = n.lane_parity_bit[i];
      end
    end
    return o;
  endfunction : merge
  task automatic wr(logic [20:0] ad, pbs_word_t d, logic [3:0] ln, logic g);
    u_host.beat(cmd(ad, d, 1'b1, ln, g));
    mem[ad] = merge(mem[ad], d, g ? ln : 4'h0);
    u_host.idle();
  endtask : wr
  task automatic rd(logic [20:0] ad, logic c);
    u_host.beat(cmd(ad, w, c, 4'hf, 1'b1));
    u_host.idle();
    repeat (2) @(negedge sys_clk_in);
    `CHK(q, mem[ad])
    `CHK(qe, 1'b0)
  endtask : rd
  task automatic results();
    $display("checks %0d errors %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    void'($urandom(78190));
    repeat (6) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    arst_n_in = 1'b1;
    for (int i = 0; i < 8; i++) begin
      a = 21'($urandom);
      w = 36'({$urandom, $urandom});
      wr(a, w, 4'hf, 1'b0);
      wr(a, ~w, 4'h5, 1'b0);
      wr(a, 36'({$urandom, $urandom}), ln_tab[i%4], 1'b1);
      rd(a, i[0]);
    end
    for (int o = 0; o < 2; o++) begin
      ord = o[0];
      a = 21'($urandom);
      for (int j = 0; j < 4; j++) wr({a[20:2], 2'(j)}, 36'({$urandom, $urandom}), 4'hf, 1'b0);
      s = cmd(a, w, 1'b1, 4'hf, 1'b1);
      u_host.beat(s);
      s.controller_addr_strobe_n = 1'b1;
      s.burst_advance_n = 1'b0;
      repeat (3) u_host.beat(s);
      for (int k = 0; k < 4; k++) begin
        `CHK(q, mem[{a[20:2], ord ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k)}])
        u_host.idle();
      end
    end
    rd(a, 1'b0);
    oe_n = 1'b1;
    #1 `CHK(qe, 1'b1)
    oe_n = 1'b0;
    #1 `CHK(qe, 1'b0)
    sleep = 1'b1;
    #1 `CHK(qe, 1'b1)
    @(negedge sys_clk_in);
    sleep = 1'b0;
    u_host.beat(cmd(a, w, 1'b1, 4'hf, 1'b1));
    u_host.idle();
    sleep = 1'b1;
    @(negedge sys_clk_in);
    sleep = 1'b0;
    @(negedge sys_clk_in);
    `CHK(qe, 1'b1)
    s = cmd(a, w, 1'b1, 4'hf, 1'b1);
    s.chip_select_depth_hi = 1'b0;
    u_host.beat(s);
    u_host.idle();
    repeat (2) @(negedge sys_clk_in);
    `CHK(qe, 1'b1)
    results();
  end
endmodule : testbench
bind pbs_port pbs_monitor u_mon (.*);
